// File: pss_pkg.sv
// Constants, types and helpers shared by the power state sequencer
package pss_pkg;
  localparam int N_REG = 15;
  localparam int ALIVE_IDX = 14;
  localparam int N_HW_IN = 2;
  localparam logic [2:0] FIRST_SLOT = 3'h1;
  localparam logic [2:0] LAST_SLOT = 3'h5;

  // Register indices on the word-addressed bus; byte address is four times these
  localparam logic [15:0] IDX_PWR_STATE = 16'h4003;
  localparam logic [15:0] IDX_MAIN_STATE = 16'h400d;
  localparam logic [15:0] IDX_ON_CAUSE = 16'h400e;
  localparam logic [15:0] IDX_OFF_CAUSE = 16'h400f;
  localparam logic [15:0] IDX_SYS_CTRL = 16'h4010;
  localparam logic [15:0] IDX_CFG_BASE = 16'h4020;

  localparam int PS_ON_BIT = 15;
  localparam int PS_SLP_BIT = 14;
  localparam int PS_DLY_LSB = 10;
  localparam logic [1:0] PS_DLY_RST = 2'h2;
  localparam int CFG_ON_LSB = 0;
  localparam int CFG_SLP_LSB = 4;
  localparam int CFG_HW_BIT = 8;
  localparam int CFG_SEL_BIT = 9;
  localparam int CFG_SW_BIT = 12;
  localparam int SYS_KEEP_BIT = 0;

  localparam int ONC_TRANS = 15;
  localparam int ONC_GPIO = 11;
  localparam int ONC_LOWSUP = 10;
  localparam int ONC_WDOG = 7;
  localparam int ONC_SW = 6;
  localparam int ONC_RTC = 5;
  localparam int ONC_PIN = 4;
  localparam int ONC_RST_LSB = 0;
  localparam int OFFC_INTLDO = 13;
  localparam int OFFC_SEQ = 12;
  localparam int OFFC_GPIO = 11;
  localparam int OFFC_PVDD = 10;
  localparam int OFFC_THERM = 9;
  localparam int OFFC_SW = 6;
  localparam int OFFC_PIN = 4;

  localparam logic [4:0] MS_OFF = 5'h00;
  localparam logic [4:0] MS_BUSY = 5'h01;
  localparam logic [4:0] MS_SLEEP = 5'h1c;
  localparam logic [4:0] MS_ON = 5'h1f;

  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int SLOT_MS = 2;
  localparam int DLY_SHORT_MS = 1;
  localparam int DLY_LONG_MS = 10;
  localparam int FAIL_S = 2;
  localparam int FAIL_MS = FAIL_S * 1000;

  typedef enum logic [2:0] {M_OFF, M_ON, M_SLEEP, M_DELAY, M_SEQ} mode_e;
  typedef enum logic [1:0] {K_ON, K_OFF, K_SLEEP, K_WAKE} kind_e;

  typedef struct packed {
    logic on_rtc;
    logic on_gpio;
    logic on_pin;
    logic wake_wdog;
    logic wake_gpio;
    logic low_supply_threshold;
    logic sleep_gpio;
    logic off_gpio;
    logic off_pin;
    logic off_therm;
    logic off_pvdd;
    logic off_intldo;
    logic restart;
    logic [3:0] restart_kind;
  } ev_s;

  typedef struct packed {
    logic go;
    logic restart;
    kind_e kind;
    logic [15:0] cause;
  } req_s;

  typedef logic [N_REG-1:0][15:0] cfg_t;

  function automatic logic [N_REG-1:0] slot_mask(input cfg_t cfg, input int lsb,
    input logic [2:0] slot);
    logic [N_REG-1:0] m;
    m = '0;
    for (int i = 0; i < N_REG; i++)
    begin
      m[i] = (cfg[i][lsb +: 3] == slot);
    end
    return m;
  endfunction

  function automatic logic [N_REG-1:0] assigned_mask(input cfg_t cfg);
    logic [N_REG-1:0] m;
    m = '0;
    for (int i = 0; i < N_REG; i++)
    begin
      m[i] = (cfg[i][CFG_ON_LSB +: 3] >= FIRST_SLOT) && (cfg[i][CFG_ON_LSB +: 3] <= LAST_SLOT);
    end
    return m;
  endfunction
endpackage

// File: ms_tick.sv
// Millisecond enable pulse divider with restart
`timescale 1ns/100ps
module ms_tick
  import pss_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_s;

  tick_s st_ff;
  tick_s nxt_st;

  always_comb
  begin
    nxt_st.tick = 1'b0;
    nxt_st.cnt = st_ff.cnt + 32'h1;
    if (restart)
      nxt_st.cnt = 32'h0;
    else if (st_ff.cnt == 32'(CYC_PER_MS_P - 1))
    begin
      nxt_st.cnt = 32'h0;
      nxt_st.tick = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign tick = st_ff.tick;
endmodule

// File: power_event_arbiter.sv
// Picks the power transition and its cause from incoming events
`timescale 1ns/100ps
module power_event_arbiter
  import pss_pkg::*;
(
  input wire mode_e mode,
  input wire ev_s ev,
  input wire logic sw_off,
  input wire logic sw_sleep,
  input wire logic sw_wake,
  output req_s req
);
  logic [15:0] off_c;

  always_comb
  begin
    off_c = 16'h0;
    off_c[OFFC_SW] = sw_off;
    off_c[OFFC_GPIO] = ev.off_gpio;
    off_c[OFFC_PIN] = ev.off_pin;
    off_c[OFFC_THERM] = ev.off_therm;
    off_c[OFFC_PVDD] = ev.off_pvdd;
    off_c[OFFC_INTLDO] = ev.off_intldo;
    req = '0;
    if (ev.restart)
    begin
      req.go = 1'b1;
      req.restart = 1'b1;
      req.cause[ONC_TRANS] = 1'b1;
      req.cause[ONC_RST_LSB +: 4] = ev.restart_kind;
    end
    else
    begin
      unique case (mode)
        M_OFF:
        begin
          // Low supply and software writes never start ON
          req.go = ev.on_rtc || ev.on_gpio || ev.on_pin;
          req.kind = K_ON;
          req.cause[ONC_TRANS] = 1'b1;
          req.cause[ONC_RTC] = ev.on_rtc;
          req.cause[ONC_GPIO] = ev.on_gpio;
          req.cause[ONC_PIN] = ev.on_pin;
        end
        M_ON:
        begin
          if (|off_c)
          begin
            req.go = 1'b1;
            req.kind = K_OFF;
            req.cause = off_c;
          end
          else if (sw_sleep || ev.sleep_gpio)
          begin
            req.go = 1'b1;
            req.kind = K_SLEEP;
          end
        end
        M_SLEEP:
        begin
          if (|off_c)
          begin
            req.go = 1'b1;
            req.kind = K_OFF;
            req.cause = off_c;
          end
          else
          begin
            req.go = sw_wake || ev.wake_wdog || ev.on_rtc || ev.wake_gpio
              || ev.low_supply_threshold;
            req.kind = K_WAKE;
            req.cause[ONC_SW] = sw_wake;
            req.cause[ONC_WDOG] = ev.wake_wdog;
            req.cause[ONC_RTC] = ev.on_rtc;
            req.cause[ONC_GPIO] = ev.wake_gpio;
            req.cause[ONC_LOWSUP] = ev.low_supply_threshold;
          end
        end
        M_DELAY, M_SEQ:
        begin
          req.go = 1'b0;
        end
      endcase
    end
  end
endmodule

// File: power_state_sequence_control.sv
// Power state sequencer for converter and regulator enables, with register slave
`timescale 1ns/100ps
module power_state_sequence_control
  import pss_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire ev_s ev,
  input wire logic [N_HW_IN-1:0] hw_enable_in,
  input wire logic [N_REG-1:0] reg_power_good,
  output logic [N_REG-1:0] reg_enable,
  output logic seq_fail
);
  typedef struct packed {
    mode_e mode;
    kind_e kind;
    logic [2:0] slot;
    logic [3:0] slot_ms;
    logic [3:0] dly_ms;
    logic [10:0] fail_ms;
    logic [N_REG-1:0] en;
    cfg_t cfg;
    logic [15:0] on_cause;
    logic [15:0] off_cause;
    logic [1:0] dly_sel;
    logic keep_alive;
    logic waitreq;
    logic [31:0] rdata;
    logic restart;
    logic fail;
  } st_s;

  st_s st_ff;
  st_s nxt_st;
  logic tick;
  logic wr_fire;
  logic ps_wr;
  logic sw_off;
  logic sw_sleep;
  logic sw_wake;
  req_s req;
  logic [3:0] dly_target;
  logic [1:0] dly_sel_now;
  logic [N_REG-1:0] grp;
  logic [N_REG-1:0] keep_mask;
  logic [N_REG-1:0] unassigned;
  logic grp_ok;
  logic last_slot;

  function automatic logic [N_REG-1:0] apply_slot(input logic [N_REG-1:0] en, input cfg_t cfg,
    input kind_e kind, input logic [2:0] slot);
    logic [N_REG-1:0] m;
    m = slot_mask(cfg, (kind == K_ON || kind == K_OFF) ? CFG_ON_LSB : CFG_SLP_LSB, slot);
    if (kind == K_ON || kind == K_WAKE)
      return en | m;
    return en & ~m;
  endfunction

  function automatic logic [15:0] read_reg(input st_s s, input logic [15:0] a);
    logic [15:0] d;
    d = 16'h0;
    if (a == IDX_PWR_STATE)
    begin
      d[PS_ON_BIT] = s.mode == M_ON || s.mode == M_SLEEP
        || ((s.mode == M_DELAY || s.mode == M_SEQ) && s.kind != K_ON);
      d[PS_SLP_BIT] = s.mode == M_SLEEP;
      d[PS_DLY_LSB +: 2] = s.dly_sel;
    end
    else if (a == IDX_MAIN_STATE)
    begin
      unique case (s.mode)
        M_OFF: d[4:0] = MS_OFF;
        M_ON: d[4:0] = MS_ON;
        M_SLEEP: d[4:0] = MS_SLEEP;
        M_DELAY, M_SEQ: d[4:0] = MS_BUSY;
      endcase
    end
    else if (a == IDX_ON_CAUSE)
      d = s.on_cause;
    else if (a == IDX_OFF_CAUSE)
      d = s.off_cause;
    else if (a == IDX_SYS_CTRL)
      d[SYS_KEEP_BIT] = s.keep_alive;
    for (int i = 0; i < N_REG; i++)
    begin
      if (a == IDX_CFG_BASE + 16'(i))
        d = s.cfg[i];
    end
    return d;
  endfunction

  ms_tick #(
    .CYC_PER_MS_P(CYC_PER_MS_P)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .restart(st_ff.restart),
    .tick(tick)
  );

  power_event_arbiter u_arb (
    .mode(st_ff.mode),
    .ev(ev),
    .sw_off(sw_off),
    .sw_sleep(sw_sleep),
    .sw_wake(sw_wake),
    .req(req)
  );

  // Write takes effect at the edge where the master sees waitrequest low
  assign wr_fire = write && !st_ff.waitreq;
  assign ps_wr = wr_fire && address == IDX_PWR_STATE && byteenable[1];
  assign sw_off = ps_wr && !writedata[PS_ON_BIT];
  assign sw_sleep = ps_wr && writedata[PS_SLP_BIT] && st_ff.mode == M_ON;
  assign sw_wake = ps_wr && !writedata[PS_SLP_BIT] && st_ff.mode == M_SLEEP;

  // A command written together with a new delay select waits the new delay
  assign dly_sel_now = ps_wr ? writedata[PS_DLY_LSB +: 2] : st_ff.dly_sel;
  assign dly_target = (dly_sel_now == 2'h2) ? 4'(DLY_SHORT_MS)
    : (dly_sel_now == 2'h3) ? 4'(DLY_LONG_MS) : 4'h0;
  assign keep_mask = st_ff.keep_alive ? (N_REG'(1) << ALIVE_IDX) : '0;
  assign unassigned = ~assigned_mask(st_ff.cfg);
  assign grp = slot_mask(st_ff.cfg, CFG_ON_LSB, st_ff.slot);
  assign grp_ok = st_ff.kind != K_ON || (grp & ~reg_power_good) == '0;
  assign last_slot = (st_ff.kind == K_ON || st_ff.kind == K_SLEEP) ? st_ff.slot == LAST_SLOT
    : st_ff.slot == FIRST_SLOT;

  always_comb
  begin
    logic start_seq;
    logic [2:0] first;
    logic [2:0] nslot;
    start_seq = 1'b0;
    first = FIRST_SLOT;
    nslot = st_ff.slot;
    nxt_st = st_ff;
    nxt_st.restart = 1'b0;
    nxt_st.fail = 1'b0;

    // Bus slave: one wait cycle, then answer
    nxt_st.waitreq = 1'b1;
    if ((read || write) && st_ff.waitreq)
    begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata = {16'h0, read_reg(st_ff, address)};
    end
    if (wr_fire)
    begin
      if (ps_wr)
        nxt_st.dly_sel = writedata[PS_DLY_LSB +: 2];
      if (address == IDX_SYS_CTRL && byteenable[0])
        nxt_st.keep_alive = writedata[SYS_KEEP_BIT];
      for (int i = 0; i < N_REG; i++)
      begin
        if (address == IDX_CFG_BASE + 16'(i))
        begin
          if (byteenable[0])
            nxt_st.cfg[i][7:0] = writedata[7:0];
          if (byteenable[1])
            nxt_st.cfg[i][15:8] = writedata[15:8];
          if (byteenable[1] && st_ff.mode == M_ON
            && !(st_ff.cfg[i][CFG_HW_BIT] && unassigned[i]))
            nxt_st.en[i] = writedata[CFG_SW_BIT];
        end
      end
    end

    // Hardware-enable followers while running
    if (st_ff.mode == M_ON || st_ff.mode == M_SLEEP)
    begin
      for (int i = 0; i < N_REG; i++)
      begin
        if (st_ff.cfg[i][CFG_HW_BIT] && unassigned[i])
          nxt_st.en[i] = hw_enable_in[st_ff.cfg[i][CFG_SEL_BIT]];
      end
    end

    unique case (st_ff.mode)
      M_OFF, M_ON, M_SLEEP:
      begin
        if (req.go)
        begin
          nxt_st.kind = req.kind;
          if (req.kind == K_ON || req.kind == K_WAKE)
            nxt_st.on_cause = req.cause;
          else if (req.kind == K_OFF)
            nxt_st.off_cause = req.cause;
          if (req.restart)
            nxt_st.en = st_ff.en & keep_mask;
          if (req.kind == K_OFF)
            nxt_st.en = nxt_st.en & (~unassigned | keep_mask);
          if (req.kind == K_OFF && st_ff.mode == M_SLEEP)
          begin
            nxt_st.en = nxt_st.en & keep_mask;
            nxt_st.mode = M_OFF;
          end
          else if (req.kind == K_ON || dly_target == 4'h0)
            start_seq = 1'b1;
          else
          begin
            nxt_st.mode = M_DELAY;
            nxt_st.dly_ms = 4'h0;
            nxt_st.restart = 1'b1;
          end
        end
      end
      M_DELAY:
      begin
        if (tick)
          nxt_st.dly_ms = st_ff.dly_ms + 4'h1;
        if (tick && st_ff.dly_ms + 4'h1 >= dly_target)
          start_seq = 1'b1;
      end
      M_SEQ:
      begin
        if (tick && st_ff.slot_ms < 4'(SLOT_MS))
          nxt_st.slot_ms = st_ff.slot_ms + 4'h1;
        if (tick && st_ff.kind == K_ON)
          nxt_st.fail_ms = st_ff.fail_ms + 11'h1;
        if (tick && st_ff.kind == K_ON && st_ff.fail_ms + 11'h1 >= 11'(FAIL_MS))
        begin
          nxt_st.en = st_ff.en & keep_mask;
          nxt_st.mode = M_OFF;
          nxt_st.off_cause = 16'h0;
          nxt_st.off_cause[OFFC_SEQ] = 1'b1;
          nxt_st.fail = 1'b1;
        end
        else if (st_ff.slot_ms >= 4'(SLOT_MS) && grp_ok)
        begin
          if (last_slot)
          begin
            unique case (st_ff.kind)
              K_ON, K_WAKE: nxt_st.mode = M_ON;
              K_OFF: nxt_st.mode = M_OFF;
              K_SLEEP: nxt_st.mode = M_SLEEP;
            endcase
          end
          else
          begin
            nslot = (st_ff.kind == K_ON || st_ff.kind == K_SLEEP) ? st_ff.slot + 3'h1
              : st_ff.slot - 3'h1;
            nxt_st.slot = nslot;
            nxt_st.slot_ms = 4'h0;
            nxt_st.restart = 1'b1;
            nxt_st.en = apply_slot(nxt_st.en, st_ff.cfg, st_ff.kind, nslot);
          end
        end
      end
    endcase

    if (start_seq)
    begin
      first = (nxt_st.kind == K_ON || nxt_st.kind == K_SLEEP) ? FIRST_SLOT : LAST_SLOT;
      nxt_st.mode = M_SEQ;
      nxt_st.slot = first;
      nxt_st.slot_ms = 4'h0;
      nxt_st.fail_ms = 11'h0;
      nxt_st.restart = 1'b1;
      nxt_st.en = apply_slot(nxt_st.en, st_ff.cfg, nxt_st.kind, first);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.dly_sel <= PS_DLY_RST;
      st_ff.waitreq <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.waitreq;
  assign reg_enable = st_ff.en;
  assign seq_fail = st_ff.fail;
endmodule

// File: reg_pg_model.sv
// Regulator power-good model with per-regulator stall
`timescale 1ns/100ps
module reg_pg_model
  import pss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [N_REG-1:0] enable,
  input wire logic [N_REG-1:0] stuck,
  output logic [N_REG-1:0] power_good
);
  logic [N_REG-1:0] ramp_ff;
  // One-cycle soft start; good drops at once on disable
  always_ff @(posedge clk)
  begin
    if (rst)
      ramp_ff <= '0;
    else
      ramp_ff <= enable;
  end
  assign power_good = ramp_ff & enable & ~stuck;
endmodule

// File: pss_checker_asserts.sv
// Port-level checks for the power state sequencer
`timescale 1ns/100ps
module pss_checker_asserts
  import pss_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire ev_s ev,
  input wire logic [N_HW_IN-1:0] hw_enable_in,
  input wire logic [N_REG-1:0] reg_power_good,
  input wire logic [N_REG-1:0] reg_enable,
  input wire logic seq_fail
);
  logic fresh_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Power state register untouched since reset
  always_ff @(posedge clk)
  begin
    if (rst)
      fresh_ff <= 1'b1;
    else if (write && !waitrequest && address == IDX_PWR_STATE)
      fresh_ff <= 1'b0;
  end

  property p_ans_next;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_ans_next: assert property (p_ans_next) else $error("request not answered");
  property p_ans_once;
    !waitrequest |=> waitrequest;
  endproperty
  a_ans_once: assert property (p_ans_once) else $error("answer too long");
  property p_hi_zero;
    !waitrequest |-> readdata[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_dly_reset;
    read && !waitrequest && address == IDX_PWR_STATE && fresh_ff |-> readdata[15:0] == 16'h0800;
  endproperty
  a_dly_reset: assert property (p_dly_reset) else $error("power state reset value");
  property p_slp_on;
    read && !waitrequest && address == IDX_PWR_STATE && readdata[14] |-> readdata[15];
  endproperty
  a_slp_on: assert property (p_slp_on) else $error("sleep without system on");
  property p_sw_on;
    (write && !waitrequest && address == IDX_PWR_STATE && writedata[15:14] == 2'h3
      && reg_enable == '0 ##1 (ev == '0 && hw_enable_in == '0) [*8]) |-> reg_enable == '0;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("software on started power up");
  property p_fail_once;
    seq_fail |=> !seq_fail [*8];
  endproperty
  a_fail_once: assert property (p_fail_once) else $error("failure pulse repeated");
  property p_fail_off;
    seq_fail |-> ##[0:2] reg_enable[13:0] == '0;
  endproperty
  a_fail_off: assert property (p_fail_off) else $error("enables kept after failure");
endmodule

// File: testbench.sv
// Self-checking bench for the power state sequencer
`timescale 1ns/100ps
module testbench
  import pss_pkg::*;
;
  logic clk, rst, read, write, waitrequest, seq_fail;
  logic [15:0] address;
  logic [31:0] writedata, readdata, rdat;
  logic [3:0] byteenable;
  logic [N_HW_IN-1:0] hw_enable_in;
  logic [N_REG-1:0] reg_power_good, reg_enable, stuck;
  ev_s ev;
  int miscompares, num_checks;

  power_state_sequence_control #(.CYC_PER_MS_P(20)) u_dut (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .ev(ev),
    .hw_enable_in(hw_enable_in), .reg_power_good(reg_power_good),
    .reg_enable(reg_enable), .seq_fail(seq_fail));
  reg_pg_model u_pg (.clk(clk), .rst(rst), .enable(reg_enable), .stuck(stuck),
    .power_good(reg_power_good));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask

  task automatic fail_out();
    miscompares++;
    end_of_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    address <= a;
    writedata <= {16'h0000, wd};
    byteenable <= 4'h3;
    read <= rd;
    write <= ~rd;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20)
      fail_out();
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    xfer(1'b0, a, d);
  endtask

  task automatic rdc(input string what, input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b1, a, 16'h0000);
    chk(what, rdat, exp);
  endtask

  task automatic wait_state(input logic [15:0] st);
    int n;
    n = 0;
    xfer(1'b1, IDX_MAIN_STATE, 16'h0000);
    while (rdat[15:0] !== st && n < 400)
    begin
      xfer(1'b1, IDX_MAIN_STATE, 16'h0000);
      n++;
    end
    if (n >= 400)
      fail_out();
  endtask

  task automatic fire(input ev_s e);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask

  task automatic t_reset();
    rdc("pwr", IDX_PWR_STATE, 32'h0800);
    wr(IDX_ON_CAUSE, 16'hffff);
    rdc("oncause", IDX_ON_CAUSE, 32'h0);
    rdc("unmapped", 16'h5000, 32'h0);
    wr(IDX_PWR_STATE, 16'hc800);
    cyc(60);
    chk("en", 32'(reg_enable), 32'h0);
    rdc("pwr2", IDX_PWR_STATE, 32'h0800);
  endtask

  task automatic t_on();
    ev_s e;
    e = '0;
    e.on_pin = 1'b1;
    wr(IDX_CFG_BASE, 16'h0001);
    wr(IDX_CFG_BASE + 16'h1, 16'h0015);
    wr(IDX_CFG_BASE + 16'h3, 16'h0100);
    fire(e);
    chk("slot1", 32'(reg_enable), 32'h1);
    rdc("pwr seq", IDX_PWR_STATE, 32'h0800);
    rdc("cause", IDX_ON_CAUSE, 32'h8010);
    wait_state(16'h001f);
    chk("on en", 32'(reg_enable), 32'h3);
    rdc("pwr on", IDX_PWR_STATE, 32'h8800);
    hw_enable_in <= 2'b01;
    cyc(3);
    chk("hw", 32'(reg_enable), 32'hb);
    hw_enable_in <= 2'b00;
    wr(IDX_CFG_BASE + 16'h2, 16'h1000);
    cyc(2);
    chk("sw on", 32'(reg_enable), 32'h7);
    wr(IDX_CFG_BASE, 16'h0001);
    cyc(2);
    chk("sw off", 32'(reg_enable), 32'h6);
    wr(IDX_CFG_BASE, 16'h1001);
    cyc(2);
    chk("sw back", 32'(reg_enable), 32'h7);
  endtask

  task automatic t_sleep();
    wr(IDX_PWR_STATE, 16'hc000);
    wait_state(16'h001c);
    chk("slp en", 32'(reg_enable), 32'h5);
    rdc("pwr slp", IDX_PWR_STATE, 32'hc000);
    wr(IDX_CFG_BASE + 16'h1, 16'h0055);
    wr(IDX_PWR_STATE, 16'h8000);
    cyc(4);
    chk("wake", 32'(reg_enable), 32'h7);
    wait_state(16'h001f);
    rdc("wake cause", IDX_ON_CAUSE, 32'h0040);
  endtask

  task automatic t_off();
    int n;
    n = 0;
    hw_enable_in <= 2'b01;
    wr(IDX_PWR_STATE, 16'h8c00);
    chk("hw2", 32'(reg_enable), 32'hf);
    wr(IDX_PWR_STATE, 16'h0c00);
    cyc(1);
    chk("off now", 32'(reg_enable), 32'h3);
    while (reg_enable[1] === 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk("dly", 32'(n >= 190 && n <= 215), 32'h1);
    chk("rev", 32'(reg_enable), 32'h1);
    wait_state(16'h0000);
    chk("off en", 32'(reg_enable), 32'h0);
    rdc("offcause", IDX_OFF_CAUSE, 32'h0040);
    rdc("pwr off", IDX_PWR_STATE, 32'h0c00);
    hw_enable_in <= 2'b00;
  endtask

  task automatic t_low();
    ev_s e;
    e = '0;
    e.low_supply_threshold = 1'b1;
    fire(e);
    cyc(50);
    chk("low", 32'(reg_enable), 32'h0);
    rdc("low st", IDX_MAIN_STATE, 32'h0);
  endtask

  task automatic t_fail();
    ev_s e;
    int n;
    e = '0;
    n = 0;
    e.on_gpio = 1'b1;
    stuck <= 15'h0001;
    fire(e);
    rdc("gpio cause", IDX_ON_CAUSE, 32'h8800);
    cyc(300);
    chk("stall", 32'(reg_enable), 32'h1);
    while (seq_fail !== 1'b1 && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 60000)
      fail_out();
    chk("fail time", 32'(n >= 39000), 32'h1);
    cyc(2);
    chk("fail en", 32'(reg_enable), 32'h0);
    rdc("fail cause", IDX_OFF_CAUSE, 32'h1000);
    stuck <= '0;
    wait_state(16'h0000);
  endtask

  task automatic t_restart();
    ev_s e;
    e = '0;
    e.restart = 1'b1;
    e.restart_kind = 4'h4;
    fire(e);
    rdc("rst cause", IDX_ON_CAUSE, 32'h8004);
    wait_state(16'h001f);
    wr(IDX_PWR_STATE, 16'hc000);
    wait_state(16'h001c);
    chk("slp keep", 32'(reg_enable[0]), 32'h1);
    e = '0;
    e.off_pin = 1'b1;
    fire(e);
    chk("slp off", 32'(reg_enable), 32'h0);
    rdc("pin cause", IDX_OFF_CAUSE, 32'h0010);
    rdc("slp off st", IDX_MAIN_STATE, 32'h0);
  endtask

  task automatic t_wake();
    ev_s e;
    e = '0;
    e.on_rtc = 1'b1;
    fire(e);
    rdc("rtc cause", IDX_ON_CAUSE, 32'h8020);
    wait_state(16'h001f);
    wr(IDX_SYS_CTRL, 16'h0001);
    wr(IDX_CFG_BASE + 16'he, 16'h1010);
    wr(IDX_PWR_STATE, 16'hcc00);
    cyc(100);
    chk("slp dly", 32'(reg_enable), 32'h4003);
    wait_state(16'h001c);
    chk("slp en2", 32'(reg_enable), 32'h0001);
    e = '0;
    e.wake_wdog = 1'b1;
    fire(e);
    wait_state(16'h001f);
    rdc("wdog cause", IDX_ON_CAUSE, 32'h0080);
    chk("wdog en", 32'(reg_enable), 32'h4003);
    e = '0;
    e.sleep_gpio = 1'b1;
    fire(e);
    wait_state(16'h001c);
    e = '0;
    e.wake_gpio = 1'b1;
    e.low_supply_threshold = 1'b1;
    fire(e);
    wait_state(16'h001f);
    rdc("low cause", IDX_ON_CAUSE, 32'h0c00);
    e = '0;
    e.off_therm = 1'b1;
    fire(e);
    wait_state(16'h0000);
    chk("alive", 32'(reg_enable), 32'h4000);
    rdc("therm cause", IDX_OFF_CAUSE, 32'h0200);
  endtask

  initial
  begin
    miscompares = 0;
    num_checks = 0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = '0;
    hw_enable_in = '0;
    stuck = '0;
    ev = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_on();
    t_sleep();
    t_off();
    t_low();
    t_fail();
    t_restart();
    t_wake();
    end_of_test();
  end
endmodule

bind power_state_sequence_control pss_checker_asserts #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_chk (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .ev(ev), .hw_enable_in(hw_enable_in),
  .reg_power_good(reg_power_good), .reg_enable(reg_enable), .seq_fail(seq_fail));
